// ### core/ssm_pkg.sv
`default_nettype none

package ssm_pkg;

  // ----------------------------------------------------------------
  // widths and encodings
  // ----------------------------------------------------------------
  localparam int UNIT_ID_W = 5;
  localparam int VW_COUNT  = 6;

  // virtual wire bit positions in the held wire vector
  localparam int VW_NUM_ERR_IGN = 0;
  localparam int VW_ADDR20_MASK = 1;
  localparam int VW_FP_ERROR    = 2;
  localparam int VW_STOP_CLOCK  = 3;
  localparam int VW_MGMT_ACK    = 4;
  localparam int VW_MGMT_INT    = 5;

  localparam logic VW_ASSERTED   = 1'b1;
  localparam logic VW_DEASSERTED = 1'b0;

  localparam logic [VW_COUNT-1:0] VW_RESET = 6'h00;

  // message kinds sent upstream
  typedef enum logic [1:0] {
    SSM_MSG_MGMT_INT  = 2'b00,
    SSM_MSG_STOP_CLK  = 2'b01,
    SSM_MSG_RESPONSE  = 2'b10,
    SSM_MSG_OTHER     = 2'b11
  } ssm_msg_kind_type;

  typedef struct packed {
    ssm_msg_kind_type       kind;
    logic [UNIT_ID_W-1:0]   unit_identifier;
    logic                   pass_posted_write_flag;
    logic                   target_done_response;
    logic                   wire_level;
  } ssm_msg_type;

  // request from host-facing core: a host transaction and its side effects
  typedef struct packed {
    logic                   needs_response;
    logic                   target_done_response;
    logic                   pass_posted_write_flag;
    logic [UNIT_ID_W-1:0]   unit_identifier;
    logic                   want_mgmt_int;
    logic                   want_stop_clk;
    logic                   stop_clk_level;
  } ssm_host_req_type;

endpackage : ssm_pkg

`default_nettype wire

// ### core/ssm_msg_order.sv
// ----------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module ssm_msg_order (
  input  wire logic                      core_clk_i,   // link clock
  input  wire logic                      rst_i,        // sync reset, high
  input  wire logic                      req_valid_i,  // host transaction done
  input  wire ssm_pkg::ssm_host_req_type req_i,        // its response and side effects
  input  wire logic                      async_int_i,  // local management interrupt source
  input  wire logic                      init_sent_i,  // processor init message sent
  input  wire logic                      host_en_i,    // host enables upstream interrupt and stop-clock messages
  input  wire logic                      ack_msg_i,    // acknowledge message received
  input  wire logic                      ack_level_i,  // its wire level
  input  wire logic                      msg_ready_i,  // upstream accepts message
  output logic                           req_ready_o,  // may take a host transaction
  output logic                           msg_valid_o,  // upstream message valid
  output ssm_pkg::ssm_msg_type           msg_o,        // upstream message
  output logic [ssm_pkg::VW_COUNT-1:0]   wires_o,      // held virtual wire states
  output logic                           int_pend_o    // interrupt outstanding
);
  import ssm_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSM_IDLE = 2'b00,
    SSM_MSG  = 2'b01,
    SSM_RESP = 2'b10
  } ssm_state_type;

  ssm_state_type            state_ff, nxt_state;
  ssm_host_req_type         req_ff;
  logic                     msg_valid_ff;
  ssm_msg_type              msg_ff, nxt_msg;
  logic [VW_COUNT-1:0]      wires_ff;
  logic                     int_pend_ff;
  logic                     up_en_ff;
  logic                     async_pend_ff;
  logic                     req_ready_ff, nxt_req_ready;
  ssm_state_type            state_after;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire msg_take   = msg_valid_ff && msg_ready_i;
  wire idle       = (state_ff == SSM_IDLE) && !msg_valid_ff;
  wire take_req   = req_valid_i && idle;
  // interrupt blocked while one is outstanding or upstream is disabled
  wire int_ok     = !int_pend_ff && up_en_ff;
  wire req_int    = req_ff.want_mgmt_int && int_ok;
  wire req_msg    = (req_ff.want_stop_clk && up_en_ff) || req_int;
  wire async_go   = idle && !req_valid_i && async_pend_ff && int_ok;
  wire sent_int   = msg_take && (msg_ff.kind == SSM_MSG_MGMT_INT);
  wire ack_assert = ack_msg_i && (ack_level_i == VW_ASSERTED);

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_msg   = msg_ff;
    unique case (state_ff)
      SSM_IDLE: begin
        if (take_req) nxt_state = SSM_MSG;
        else if (async_go) begin
          nxt_msg.kind                   = SSM_MSG_MGMT_INT;
          nxt_msg.unit_identifier        = '0;
          nxt_msg.pass_posted_write_flag = 1'b0;
          nxt_msg.target_done_response   = 1'b0;
          nxt_msg.wire_level             = VW_ASSERTED;
        end
      end
      SSM_MSG: begin
        if (req_msg) begin
          nxt_state = req_ff.needs_response ? SSM_RESP : SSM_IDLE;
          nxt_msg.unit_identifier        = req_ff.unit_identifier;
          nxt_msg.kind                   = req_int ? SSM_MSG_MGMT_INT : SSM_MSG_STOP_CLK;
          nxt_msg.wire_level             = req_int ? VW_ASSERTED : req_ff.stop_clk_level;
          nxt_msg.pass_posted_write_flag = 1'b0;
          nxt_msg.target_done_response   = 1'b0;
        end else begin
          nxt_state = SSM_IDLE;
          nxt_msg.kind                   = SSM_MSG_RESPONSE;
          nxt_msg.unit_identifier        = req_ff.unit_identifier;
          nxt_msg.pass_posted_write_flag = req_ff.pass_posted_write_flag;
          nxt_msg.target_done_response   = req_ff.target_done_response;
          nxt_msg.wire_level             = VW_DEASSERTED;
        end
      end
      SSM_RESP: begin
        nxt_state                      = SSM_IDLE;
        nxt_msg.kind                   = SSM_MSG_RESPONSE;
        nxt_msg.unit_identifier        = req_ff.unit_identifier;
        nxt_msg.pass_posted_write_flag = 1'b0;
        nxt_msg.target_done_response   = req_ff.target_done_response;
        nxt_msg.wire_level             = VW_DEASSERTED;
      end
      default: nxt_state = SSM_IDLE;
    endcase
  end

  // a new message is loaded only when the output slot is free
  wire load_msg = !msg_valid_ff &&
                  ((state_ff == SSM_MSG) && (req_msg || req_ff.needs_response) ||
                   (state_ff == SSM_RESP) || async_go);
  wire advance  = !msg_valid_ff || (state_ff == SSM_IDLE);

  // ready is registered from next-cycle state and slot, so it leaves as a flop
  assign state_after   = advance ? nxt_state : state_ff;
  assign nxt_req_ready = (state_after == SSM_IDLE) && !load_msg &&
                         !(msg_valid_ff && !msg_take);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_ff     <= SSM_IDLE;
      req_ready_ff <= 1'b1;
      msg_valid_ff <= 1'b0;
      msg_ff       <= '0;
      req_ff       <= '0;
    end else begin
      if (advance) state_ff <= nxt_state;
      req_ready_ff <= nxt_req_ready;
      if (load_msg) msg_ff <= nxt_msg;
      if (take_req) req_ff <= req_i;
      if (load_msg) msg_valid_ff <= 1'b1;
      else if (msg_take) msg_valid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt bookkeeping and enable
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      int_pend_ff   <= 1'b0;
      up_en_ff      <= 1'b0;
      async_pend_ff <= 1'b0;
    end else begin
      // set on send wins over ack
      if (sent_int) int_pend_ff <= 1'b1;
      else if (ack_assert) int_pend_ff <= 1'b0;
      if (init_sent_i) up_en_ff <= 1'b0;
      else if (host_en_i) up_en_ff <= 1'b1;
      if (async_int_i) async_pend_ff <= 1'b1;
      else if (async_go) async_pend_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // held virtual wires
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wires_ff <= VW_RESET;
    end else begin
      if (msg_take && msg_ff.kind == SSM_MSG_STOP_CLK)
        wires_ff[VW_STOP_CLOCK] <= msg_ff.wire_level;
      if (sent_int) wires_ff[VW_MGMT_INT] <= VW_ASSERTED;
      else if (ack_assert) wires_ff[VW_MGMT_INT] <= VW_DEASSERTED;
      if (ack_msg_i) wires_ff[VW_MGMT_ACK] <= ack_level_i;
    end
  end

  assign msg_valid_o = msg_valid_ff;
  assign msg_o       = msg_ff;
  assign wires_o     = wires_ff;
  assign int_pend_o  = int_pend_ff;
  assign req_ready_o = req_ready_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  one_outstanding_a : assert property (
    int_pend_ff && !ack_assert |-> !(msg_valid_ff && msg_ff.kind == SSM_MSG_MGMT_INT
                                     && $rose(msg_valid_ff)))
    else $error("second interrupt before acknowledge");

  pend_set_a : assert property (
    sent_int |=> int_pend_ff)
    else $error("outstanding flag not set");

  ack_clear_a : assert property (
    ack_assert && !sent_int |=> !int_pend_ff)
    else $error("acknowledge did not clear flag");

  resp_flag_a : assert property (
    msg_valid_ff && msg_ff.kind == SSM_MSG_RESPONSE && state_ff == SSM_IDLE
      && $past(state_ff) == SSM_RESP |-> !msg_ff.pass_posted_write_flag)
    else $error("response may pass message");

  order_id_a : assert property (
    msg_take && msg_ff.kind inside {SSM_MSG_MGMT_INT, SSM_MSG_STOP_CLK} ##2 msg_valid_ff
      && msg_ff.kind == SSM_MSG_RESPONSE
      |-> msg_ff.unit_identifier == $past(msg_ff.unit_identifier, 2))
    else $error("unit identifier mismatch");

  no_enable_a : assert property (
    !up_en_ff && load_msg |-> nxt_msg.kind == SSM_MSG_RESPONSE)
    else $error("message sent while disabled");

  reset_wires_a : assert property (
    $past(rst_i) |-> wires_ff == VW_RESET)
    else $error("wires not deasserted after reset");

  msg_first_a : assert property (
    state_ff == SSM_RESP && msg_valid_ff |-> msg_ff.kind != SSM_MSG_RESPONSE)
    else $error("response before message");

  cov_int_c   : cover property (sent_int ##[1:20] ack_assert);
  cov_order_c : cover property (msg_take && msg_ff.kind == SSM_MSG_STOP_CLK ##[1:5]
                                msg_take && msg_ff.kind == SSM_MSG_RESPONSE);
  cov_dup_c   : cover property (ack_assert ##[1:10] ack_assert);

endmodule : ssm_msg_order

`default_nettype wire

// ### verification/ssm_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module ssm_host_model
  import ssm_pkg::*;
(
  input  wire logic        core_clk_i,  // link clock
  input  wire logic        rst_i,       // sync reset, high
  input  wire logic        stall_i,     // hold off upstream acceptance
  input  wire logic        auto_ack_i,  // answer interrupts
  input  wire logic        dup_i,       // repeat the acknowledge assertion
  input  wire logic        msg_valid_i, // upstream message valid
  input  wire ssm_msg_type msg_i,       // upstream message
  output logic             msg_ready_o, // message accepted
  output logic             ack_msg_o,   // acknowledge message pulse
  output logic             ack_level_o  // its wire level
);
  int cnt;

  assign msg_ready_o = ~stall_i;

  // ----------------------------------------------------------------
  // acknowledge sequence
  // ----------------------------------------------------------------
  // one assertion (a second one when dup_i is set), later deassertion
  always @(posedge core_clk_i) begin
    ack_msg_o   <= 1'b0;
    // idle level toggles so a stale value is never trusted
    ack_level_o <= ~ack_level_o;
    if (rst_i) begin
      cnt         <= 0;
      ack_level_o <= 1'b0;
    end else begin
      if (msg_valid_i && msg_ready_o && msg_i.kind == SSM_MSG_MGMT_INT)
        cnt <= 1;
      else if (cnt != 0 && auto_ack_i)
        cnt <= cnt + 1;
      if (auto_ack_i && (cnt == 4 || (cnt == 5 && dup_i))) begin
        ack_msg_o   <= 1'b1;
        ack_level_o <= 1'b1;
      end
      if (auto_ack_i && cnt == 8) begin
        ack_msg_o   <= 1'b1;
        ack_level_o <= 1'b0;
        cnt         <= 0;
      end
    end
  end
endmodule : ssm_host_model

`default_nettype wire

// ### verification/ssm_msg_order_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module ssm_msg_order_tb_top;
  import ssm_pkg::*;
  logic clk = 0, rst = 1, req_valid = 0, async_int = 0, init_sent = 0, host_en = 0;
  logic stall = 0, auto_ack = 0, dup = 0, ack_msg, ack_level, msg_ready;
  logic req_ready, msg_valid, int_pend;
  ssm_host_req_type req = '0;
  ssm_msg_type      msg;
  logic [VW_COUNT-1:0] wires;
  ssm_msg_type exp_q[$];
  int mismatches = 0, comparisons = 0;
  bit en = 0, pend = 0, stop_w = 0;

  initial forever #10 clk = ~clk;

  ssm_msg_order u_dut (.core_clk_i(clk), .rst_i(rst), .req_valid_i(req_valid), .req_i(req),
    .async_int_i(async_int), .init_sent_i(init_sent), .host_en_i(host_en),
    .ack_msg_i(ack_msg), .ack_level_i(ack_level), .msg_ready_i(msg_ready),
    .req_ready_o(req_ready), .msg_valid_o(msg_valid), .msg_o(msg), .wires_o(wires),
    .int_pend_o(int_pend));

  ssm_host_model u_host (.core_clk_i(clk), .rst_i(rst), .stall_i(stall), .auto_ack_i(auto_ack),
    .dup_i(dup), .msg_valid_i(msg_valid), .msg_i(msg), .msg_ready_o(msg_ready),
    .ack_msg_o(ack_msg), .ack_level_o(ack_level));

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // upstream monitor against the reference queue
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    stall <= ($urandom % 3 == 0);
    if (!rst && msg_valid && msg_ready) begin
      ssm_msg_type e;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : ~msg;
      `CHK({msg.kind, msg.unit_identifier}, {e.kind, e.unit_identifier})
      if (e.kind == SSM_MSG_RESPONSE)
        `CHK({msg.pass_posted_write_flag, msg.target_done_response},
             {e.pass_posted_write_flag, e.target_done_response})
      else
        `CHK(msg.wire_level, e.wire_level)
    end
  end

  task automatic drain();
    int n;
    for (n = 0; n < 300 && (exp_q.size() != 0 || !req_ready); n++) @(posedge clk);
    if (n == 300) begin
      mismatches++;
      wrap_up();
    end
  endtask : drain

  task automatic send(bit iw, bit sw, bit lvl, bit nr);
    ssm_host_req_type r;
    bit m;
    r = '{nr, 1'($urandom), 1'($urandom), 5'($urandom), iw, sw, lvl};
    m = en && ((iw && !pend) || sw);
    if (en && iw && !pend) exp_q.push_back('{SSM_MSG_MGMT_INT, r.unit_identifier, 1'b0, 1'b0, 1'b1});
    else if (en && sw) exp_q.push_back('{SSM_MSG_STOP_CLK, r.unit_identifier, 1'b0, 1'b0, lvl});
    if (en && iw) pend = 1;
    if (en && sw) stop_w = lvl;
    if (nr) exp_q.push_back('{SSM_MSG_RESPONSE, r.unit_identifier,
                              m ? 1'b0 : r.pass_posted_write_flag, r.target_done_response, 1'b0});
    req_valid <= 1'b1;
    req       <= r;
    @(posedge clk);
    req_valid <= 1'b0;
    drain();
    `CHK({wires[VW_STOP_CLOCK], wires[VW_FP_ERROR:VW_NUM_ERR_IGN]}, {stop_w, 3'b000})
  endtask : send

  // sel 0 host enable, 1 local interrupt, 2 init message
  task automatic pulse(input int sel);
    if (sel == 0) host_en <= 1'b1;
    else if (sel == 1) async_int <= 1'b1;
    else init_sent <= 1'b1;
    @(posedge clk);
    host_en   <= 1'b0;
    async_int <= 1'b0;
    init_sent <= 1'b0;
    @(posedge clk);
  endtask : pulse

  task automatic wait_ack();
    int w;
    for (w = 0; w < 40 && int_pend !== 1'b0; w++) @(posedge clk);
    `CHK(int_pend, 1'b0)
    if (w == 40) wrap_up();
    repeat (6) @(posedge clk);
    `CHK(wires[VW_MGMT_INT:VW_MGMT_ACK], 2'b00)
    pend = 0;
  endtask : wait_ack

  initial begin
    int k;
    void'($urandom(32'h2c917a41));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK({msg_valid, wires, int_pend, req_ready}, {1'b0, VW_RESET, 1'b0, 1'b1})
    send(1, 0, 0, 0);
    repeat (8) @(posedge clk);
    `CHK({msg_valid, int_pend}, 2'b00)
    pulse(0);
    en = 1;
    pend = 0;
    send(1, 0, 0, 1);
    `CHK({int_pend, wires[VW_MGMT_INT]}, 2'b11)
    send(1, 0, 0, 1);
    `CHK(int_pend, 1'b1)
    auto_ack <= 1'b1;
    dup      <= 1'b1;
    for (k = 0; k < 24; k++) begin
      if (pend) wait_ack();
      case (k % 4)
        0: send(1, 0, 0, 1);
        1: send(0, 1, 1, 1);
        2: send(0, 1, 0, 1);
        default: send(0, 0, 0, 1);
      endcase
      dup <= 1'($urandom);
    end
    wait_ack();
    exp_q.push_back('{SSM_MSG_MGMT_INT, 5'h00, 1'b0, 1'b0, 1'b1});
    pend = 1;
    pulse(1);
    drain();
    pulse(2);
    en = 0;
    send(0, 1, 1, 1);
    wrap_up();
  end
endmodule : ssm_msg_order_tb_top

`default_nettype wire
